// ### shared/pmic_i2c_cfg.svh
// Purpose: constants shared by both ends of the register port link
// Assumes: mclk at 40 MHz
// Notes:   the target address is an arbitrary value
`ifndef PMIC_I2C_CFG_SVH
`define PMIC_I2C_CFG_SVH
// ----------------------------------------
// link addressing and framing
// ----------------------------------------
`define PMIC_DEV_ADDR  7'h2A // arbitrary value
`define PMIC_RD_BIT    1'b1
`define PMIC_LAST_BIT  4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define PMIC_MCLK_NS   25
`define PMIC_SCL_NS    2500
`define PMIC_QTR_CYC   (`PMIC_SCL_NS / `PMIC_MCLK_NS / 4)
// ----------------------------------------
// buffering
// ----------------------------------------
`define PMIC_FIFO_W    16
`define PMIC_FIFO_D    16
`define PMIC_SYNC_IDLE 3'h7
`endif

// ### shared/pmic_pkg.sv
// Purpose: types shared by both ends of the register port link
// Assumes: constants come from pmic_i2c_cfg.svh
// Notes:   the sync helper filters a pin pair through three flops
package pmic_pkg;
	// ----------------------------------------
	// states and commands
	// ----------------------------------------
	typedef enum logic [2:0] {
		D_IDLE = 3'b000, D_RX = 3'b001, D_ACKO = 3'b010,
		D_TX = 3'b011, D_ACKI = 3'b100, D_IGN = 3'b101
	} pmic_dst_t;
	typedef enum logic [1:0] {K_ADDR = 2'b00, K_REG = 2'b01, K_DATA = 2'b10} pmic_kind_t;
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11} pmic_hst_t;
	typedef enum logic [1:0] {OP_START = 2'b00, OP_WRITE = 2'b01, OP_READ = 2'b10, OP_STOP = 2'b11} pmic_op_t;
	// ----------------------------------------
	// pin synchroniser state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic       scl;
		logic       sda;
	} pmic_sync_t;

	// bit 0 is the first flop; only bit 1 reads it
	function automatic pmic_sync_t pmic_sync(pmic_sync_t s, logic scl, logic sda);
		pmic_sync_t r;
		r = s;
		r.scl_s = {s.scl_s[1:0], scl};
		r.sda_s = {s.sda_s[1:0], sda};
		if (s.scl_s[1] == s.scl_s[2]) begin
			r.scl = s.scl_s[2];
		end
		if (s.sda_s[1] == s.sda_s[2]) begin
			r.sda = s.sda_s[2];
		end
		return r;
	endfunction : pmic_sync
endpackage : pmic_pkg

// ### shared/pmic_i2c_if.sv
// Purpose: two-wire open-drain link between controller and target
// Assumes: each end drives only output enables with a low data value
// Notes:   a line is low while any end enables a low drive
`timescale 1ns/1ps
interface pmic_i2c_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_scl_o;
	logic d_scl_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// wired-and of both ends, pulled up when nobody drives
	assign scl = !((h_scl_oe && !h_scl_o) || (d_scl_oe && !d_scl_o));
	assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
	modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, input scl, sda);
	modport dev  (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, input scl, sda);
endinterface : pmic_i2c_if

// ### design/pmic_dev.sv
// Purpose: target end of the register port link, plus its write FIFO
// Assumes: register storage lives outside; it answers rd_data for rd_reg
// Notes:   SCL is held low while a received data byte waits on a full write FIFO
`timescale 1ns/1ps
`include "pmic_i2c_cfg.svh"

module pmic_fifo import pmic_pkg::*; #(
	parameter int W = `PMIC_FIFO_W,
	parameter int D = `PMIC_FIFO_D
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} pmic_fifo_st_t;
	pmic_fifo_st_t s;
	pmic_fifo_st_t n;
	logic          push;
	logic          pop;

	// honest flags straight from the occupancy count
	assign in_ready  = (s.cnt != (AW + 1)'(D));
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointers wrap because depth is a power of two
	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp = s.wp + 1'b1;
		end
		if (pop) begin
			n.rp = s.rp + 1'b1;
		end
		n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule : pmic_fifo

module pmic_dev import pmic_pkg::*; (
	// clock and reset
	input  wire logic   mclk,
	input  wire logic   rst,
	// link pins
	pmic_i2c_if.dev     bus,
	// register write stream
	output logic        wr_valid,
	input  wire logic   wr_ready,
	output logic [7:0]  wr_reg,
	output logic [7:0]  wr_data,
	// register read port
	output logic [7:0]  rd_reg,
	input  wire logic [7:0] rd_data
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pmic_sync_t sy;
		pmic_dst_t  st;
		pmic_kind_t kind;
		logic       rd;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic       nack;
		logic       hold;
		logic       sda_oe;
		logic       scl_oe;
		logic       zero;
		logic       ov;
		logic [15:0] od;
	} pmic_dev_st_t;
	pmic_dev_st_t s;
	pmic_dev_st_t n;

	logic        f_in_valid;
	logic        f_in_ready;
	logic        f_out_valid;
	logic        f_out_ready;
	logic [15:0] f_out_data;

	// ----------------------------------------
	// write buffer
	// ----------------------------------------
	// a data byte is offered once all eight bits are in
	assign f_in_valid = (s.st == D_RX) && (s.kind == K_DATA) &&
		(s.cnt == `PMIC_LAST_BIT) && (s.hold || (s.sy.scl && !n.sy.scl));
	assign f_out_ready = !s.ov || wr_ready;

	pmic_fifo #(.W(`PMIC_FIFO_W), .D(`PMIC_FIFO_D)) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   ({s.ptr, s.sh}),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// ----------------------------------------
	// link engine
	// ----------------------------------------
	// edges are taken from the filtered levels only
	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic ld;
		rise  = 1'b0;
		fall  = 1'b0;
		start = 1'b0;
		stop  = 1'b0;
		ld    = 1'b0;
		n = s;
		n.sy  = pmic_sync(s.sy, bus.scl, bus.sda);
		rise  = !s.sy.scl && n.sy.scl;
		fall  = s.sy.scl && !n.sy.scl;
		start = s.sy.scl && n.sy.scl && s.sy.sda && !n.sy.sda;
		stop  = s.sy.scl && n.sy.scl && !s.sy.sda && n.sy.sda;
		if (start) begin
			// a repeated start resyncs exactly like a fresh one
			n.st = D_RX;
			n.kind = K_ADDR;
			n.cnt = '0;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.hold = 1'b0;
		end else if (stop) begin
			n.st = D_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.hold = 1'b0;
		end else begin
			case (s.st)
				D_RX: begin
					if (rise && (s.cnt != `PMIC_LAST_BIT)) begin
						n.sh = {s.sh[6:0], n.sy.sda};
						n.cnt = s.cnt + 4'h1;
					end else if ((s.cnt == `PMIC_LAST_BIT) && (fall || s.hold)) begin
						n.cnt = '0;
						case (s.kind)
							K_ADDR: begin
								if (s.sh[7:1] == `PMIC_DEV_ADDR) begin
									n.rd = (s.sh[0] == `PMIC_RD_BIT);
									n.sda_oe = 1'b1;
									n.st = D_ACKO;
									n.kind = K_REG;
								end else begin
									n.st = D_IGN;
								end
							end
							K_REG: begin
								// no data needs to follow
								n.ptr = s.sh;
								n.sda_oe = 1'b1;
								n.st = D_ACKO;
								n.kind = K_DATA;
							end
							default: begin
								if (f_in_ready) begin
									n.ptr = s.ptr + 8'h01;
									n.sda_oe = 1'b1;
									n.st = D_ACKO;
									// the held clock is let go one cycle later, in D_ACKO
									n.hold = 1'b0;
								end else begin
									// stretch the clock instead of dropping a byte
									n.hold = 1'b1;
									n.scl_oe = 1'b1;
									n.cnt = s.cnt;
								end
							end
						endcase
					end
				end
				D_ACKO: begin
					// ack settles first, so SDA never moves while SCL is high
					if (s.scl_oe) begin
						n.scl_oe = 1'b0;
					end else if (fall) begin
						n.sda_oe = 1'b0;
						if (s.rd) begin
							ld = 1'b1;
						end else begin
							n.st = D_RX;
						end
					end
				end
				D_TX: begin
					if (rise) begin
						n.cnt = s.cnt + 4'h1;
					end else if (fall) begin
						if (s.cnt == `PMIC_LAST_BIT) begin
							n.sda_oe = 1'b0;
							n.st = D_ACKI;
						end else begin
							n.sh = {s.sh[6:0], 1'b0};
							n.sda_oe = !s.sh[6];
						end
					end
				end
				D_ACKI: begin
					if (rise) begin
						n.nack = n.sy.sda;
					end else if (fall) begin
						if (s.nack) begin
							n.st = D_IGN;
						end else begin
							ld = 1'b1;
						end
					end
				end
				default: begin
					n.sda_oe = 1'b0;
				end
			endcase
		end
		// load the next read byte from the live pointer
		if (ld) begin
			n.sh = rd_data;
			n.sda_oe = !rd_data[7];
			n.ptr = s.ptr + 8'h01;
			n.cnt = '0;
			n.st = D_TX;
		end
		// output stage keeps the write port flop-driven
		if (f_out_ready) begin
			n.ov = f_out_valid;
			n.od = f_out_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
			s.sy <= '{scl_s: `PMIC_SYNC_IDLE, sda_s: `PMIC_SYNC_IDLE, scl: 1'b1, sda: 1'b1};
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.d_scl_o  = s.zero;
	assign bus.d_scl_oe = s.scl_oe;
	assign bus.d_sda_o  = s.zero;
	assign bus.d_sda_oe = s.sda_oe;
	assign wr_valid     = s.ov;
	assign wr_reg       = s.od[15:8];
	assign wr_data      = s.od[7:0];
	assign rd_reg       = s.ptr;
endmodule : pmic_dev

// ### design/pmic_host.sv
// Purpose: controller end of the register port link
// Assumes: user sequences start, bytes and stop as commands
// Notes:   SCL is divided from mclk; a low SCL from the target stalls it
`timescale 1ns/1ps
`include "pmic_i2c_cfg.svh"

module pmic_host import pmic_pkg::*; (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// link pins
	pmic_i2c_if.host        bus,
	// command
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [1:0] cmd_op,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_ack,
	// response
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack
);
	localparam logic [5:0] QTR_LAST = 6'(`PMIC_QTR_CYC - 1);

	typedef struct packed {
		pmic_sync_t sy;
		pmic_hst_t  st;
		logic       rd;
		logic [1:0] q;
		logic [5:0] div;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       ack;
		logic       scl_oe;
		logic       sda_oe;
		logic       zero;
		logic       cready;
		logic       rvalid;
		logic [7:0] rdata;
		logic       rnack;
	} pmic_host_st_t;
	pmic_host_st_t s;
	pmic_host_st_t n;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// each bit is four quarter ticks; quarter 1 waits for SCL high
	always_comb begin
		logic tick;
		logic done;
		tick = (s.div == QTR_LAST);
		done = 1'b0;
		n = s;
		n.sy = pmic_sync(s.sy, bus.scl, bus.sda);
		n.rvalid = 1'b0;
		n.div = tick ? '0 : s.div + 6'h01;
		case (s.st)
			H_IDLE: begin
				n.cready = 1'b1;
				if (cmd_valid && s.cready) begin
					n.cready = 1'b0;
					n.rd = (cmd_op == OP_READ);
					n.sh = cmd_data;
					n.ack = cmd_ack;
					n.q = '0;
					n.cnt = '0;
					n.div = '0;
					case (cmd_op)
						OP_START: n.st = H_START;
						OP_STOP:  n.st = H_STOP;
						default:  n.st = H_BIT;
					endcase
				end
			end
			H_START: begin
				// from idle or after a byte, so it also forms a repeated start
				if (tick) begin
					case (s.q)
						2'h0: begin
							n.sda_oe = 1'b0;
							n.q = 2'h1;
						end
						2'h1: begin
							n.scl_oe = 1'b0;
							n.q = s.sy.scl ? 2'h2 : 2'h1;
						end
						2'h2: begin
							n.sda_oe = 1'b1;
							n.q = 2'h3;
						end
						default: begin
							n.scl_oe = 1'b1;
							done = 1'b1;
						end
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					case (s.q)
						2'h0: begin
							if (s.cnt == `PMIC_LAST_BIT) begin
								n.sda_oe = s.rd && s.ack;
							end else begin
								// address LSB and offset-only writes are user framing
								n.sda_oe = !s.rd && !s.sh[7];
							end
							n.q = 2'h1;
						end
						2'h1: begin
							n.scl_oe = 1'b0;
							n.q = s.sy.scl ? 2'h2 : 2'h1;
						end
						2'h2: begin
							if (s.cnt == `PMIC_LAST_BIT) begin
								n.rnack = s.sy.sda;
							end else begin
								n.sh = {s.sh[6:0], s.sy.sda};
							end
							n.q = 2'h3;
						end
						default: begin
							n.scl_oe = 1'b1;
							n.q = 2'h0;
							if (s.cnt == `PMIC_LAST_BIT) begin
								n.sda_oe = 1'b0;
								done = 1'b1;
							end else begin
								n.cnt = s.cnt + 4'h1;
							end
						end
					endcase
				end
			end
			default: begin
				if (tick) begin
					case (s.q)
						2'h0: begin
							n.sda_oe = 1'b1;
							n.q = 2'h1;
						end
						2'h1: begin
							n.scl_oe = 1'b0;
							n.q = s.sy.scl ? 2'h2 : 2'h1;
						end
						default: begin
							n.sda_oe = 1'b0;
							done = 1'b1;
						end
					endcase
				end
			end
		endcase
		// one response pulse per finished command
		if (done) begin
			n.st = H_IDLE;
			n.q = '0;
			n.rvalid = 1'b1;
			n.rdata = n.sh;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
			s.sy <= '{scl_s: `PMIC_SYNC_IDLE, sda_s: `PMIC_SYNC_IDLE, scl: 1'b1, sda: 1'b1};
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.h_scl_o  = s.zero;
	assign bus.h_scl_oe = s.scl_oe;
	assign bus.h_sda_o  = s.zero;
	assign bus.h_sda_oe = s.sda_oe;
	assign cmd_ready    = s.cready;
	assign rsp_valid    = s.rvalid;
	assign rsp_data     = s.rdata;
	assign rsp_nack     = s.rnack;
endmodule : pmic_host

// ### tb/pmic_i2c_assertions.sv
// Purpose: wire checks on the register port link
// Assumes: both ends drive the lines of pmic_i2c_if
// Notes:   lines are open drain, low only while an enable is high
`timescale 1ns/1ps
module pmic_i2c_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// line drivers
	input wire logic h_scl_oe,
	input wire logic h_sda_oe,
	input wire logic d_scl_o,
	input wire logic d_scl_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	// resolved lines
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------
	// line checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// the target may only pull low, never drive high
	drive_low_a: assert property (d_sda_o == 1'b0 && d_scl_o == 1'b0)
		else $error("target drives a line high");
	reset_off_a: assert property (disable iff (1'b0) $past(rst) |-> !d_sda_oe && !d_scl_oe && !h_sda_oe && !h_scl_oe)
		else $error("a line is pulled during reset");
	idle_lines_a: assert property ($fell(rst) |-> scl && sda && !d_sda_oe)
		else $error("lines busy after reset");
	// a change while the clock is high would read as start or stop
	sda_on_low_a: assert property ($changed(d_sda_oe) |-> !scl)
		else $error("target moved data while clock high");
	stretch_low_a: assert property ($rose(d_scl_oe) |-> !scl && h_scl_oe)
		else $error("target stretch began with clock high");
	start_quiet_a: assert property (scl && $fell(sda) |-> !d_sda_oe ##1 !d_sda_oe [*8])
		else $error("target drives data right after start");
	ack_delay_a: assert property ($rose(d_sda_oe) |-> $past(scl, 2) == 1'b0)
		else $error("target drives data too soon after clock fall");
	clk_high_a: assert property ($fell(h_scl_oe) |=> !h_scl_oe [*8])
		else $error("clock high phase too short");
endmodule : pmic_i2c_assertions

// ### tb/pmic_i2c_register_port_bench.sv
// Purpose: self-checking bench for both ends of the register port link
// Assumes: the bench holds the register file behind the target
// Notes:   one byte costs about 1130 mclk, so scenarios are few
`timescale 1ns/1ps
`include "pmic_i2c_cfg.svh"
module pmic_i2c_register_port_bench import pmic_pkg::*;;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic       mclk      = 1'b0;
	logic       rst       = 1'b1;
	logic       cmd_valid = 1'b0;
	logic [1:0] cmd_op    = 2'h0;
	logic [7:0] cmd_data  = 8'h00;
	logic       cmd_ack   = 1'b0;
	logic       wr_ready  = 1'b1;
	logic       cmd_ready, rsp_valid, rsp_nack, wr_valid;
	logic [7:0] rsp_data, wr_reg, wr_data, rd_reg, rd_data;
	logic [7:0] mem [256];
	logic [7:0] expv [256];
	int         num_errors = 0;
	int         num_checks = 0;
	int         cycles     = 0;
	int         stretch    = 0;

	pmic_i2c_if link ();
	pmic_host pmic_host_inst (.mclk(mclk), .rst(rst), .bus(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack));
	pmic_dev pmic_dev_inst (.mclk(mclk), .rst(rst), .bus(link), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_reg(wr_reg), .wr_data(wr_data), .rd_reg(rd_reg), .rd_data(rd_data));
	pmic_i2c_assertions pmic_i2c_assertions_inst (.mclk(mclk), .rst(rst), .h_scl_oe(link.h_scl_oe),
		.h_sda_oe(link.h_sda_oe), .d_scl_o(link.d_scl_o), .d_scl_oe(link.d_scl_oe), .d_sda_o(link.d_sda_o),
		.d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));

	// register file read port is combinational
	assign rd_data = mem[rd_reg];

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// register file, stretch watch and hang limit
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (wr_valid && wr_ready) mem[wr_reg] <= wr_data;
		if (link.d_scl_oe) stretch <= stretch + 1;
		if (cycles == 90000) begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, want, seen);
		end
	endtask : check

	// one command; outputs are read at falling edges, well away from updates
	task automatic put(input pmic_op_t op, input logic [7:0] data, input logic ack);
		@(negedge mclk);
		while (cmd_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_data  <= data;
		cmd_ack   <= ack;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		@(negedge mclk);
		while (rsp_valid !== 1'b1) @(negedge mclk);
	endtask : put

	task automatic open_addr(input logic [6:0] a, input logic rw, input logic want_nack);
		put(OP_START, 8'h00, 1'b0);
		put(OP_WRITE, {a, rw}, 1'b0);
		check("address ack", {7'h00, rsp_nack}, {7'h00, want_nack});
	endtask : open_addr

	task automatic wbytes(input logic [7:0] off, input int n, input logic [7:0] v0);
		put(OP_WRITE, off, 1'b0);
		check("offset ack", {7'h00, rsp_nack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			put(OP_WRITE, v0 + 8'(i), 1'b0);
			expv[off + 8'(i)] = v0 + 8'(i);
			check("data ack", {7'h00, rsp_nack}, 8'h00);
		end
	endtask : wbytes

	// last byte is not acknowledged, then stop
	task automatic rbytes(input logic [7:0] off, input int n);
		for (int i = 0; i < n; i++) begin
			put(OP_READ, 8'h00, i < n - 1);
			check("read byte", rsp_data, expv[off + 8'(i)]);
		end
		put(OP_STOP, 8'h00, 1'b0);
	endtask : rbytes

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i]  = 8'(i) ^ 8'h5A;
			expv[i] = 8'(i) ^ 8'h5A;
		end
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		// burst write, pointer set, then stop and a fresh start for the read
		open_addr(`PMIC_DEV_ADDR, 1'b0, 1'b0);
		wbytes(8'h05, 2, 8'hA5);
		put(OP_STOP, 8'h00, 1'b0);
		open_addr(`PMIC_DEV_ADDR, 1'b0, 1'b0);
		wbytes(8'h05, 0, 8'h00);
		put(OP_STOP, 8'h00, 1'b0);
		open_addr(`PMIC_DEV_ADDR, 1'b1, 1'b0);
		rbytes(8'h05, 2);
		$display("test write_read done");
		// offset-only write leaves registers alone; repeated start opens the read
		open_addr(`PMIC_DEV_ADDR, 1'b0, 1'b0);
		wbytes(8'h20, 0, 8'h00);
		open_addr(`PMIC_DEV_ADDR, 1'b1, 1'b0);
		rbytes(8'h20, 3);
		$display("test repeated_start done");
		// foreign address is ignored, so the pointer stays at 0x23
		open_addr(`PMIC_DEV_ADDR ^ 7'h01, 1'b0, 1'b1);
		put(OP_WRITE, 8'h00, 1'b0);
		check("ignored byte ack", {7'h00, rsp_nack}, 8'h01);
		put(OP_STOP, 8'h00, 1'b0);
		open_addr(`PMIC_DEV_ADDR, 1'b1, 1'b0);
		rbytes(8'h23, 1);
		$display("test foreign_address done");
		// consumer stalls until the write buffer refuses and the clock is held
		@(posedge mclk);
		wr_ready <= 1'b0;
		fork
			begin
				// free the consumer only once the target really holds the clock
				wait (stretch != 0);
				repeat (400) @(posedge mclk);
				wr_ready <= 1'b1;
			end
		join_none
		open_addr(`PMIC_DEV_ADDR, 1'b0, 1'b0);
		wbytes(8'h40, 18, 8'h10);
		put(OP_STOP, 8'h00, 1'b0);
		check("clock held", {7'h00, stretch != 0}, 8'h01);
		open_addr(`PMIC_DEV_ADDR, 1'b0, 1'b0);
		wbytes(8'h40, 0, 8'h00);
		put(OP_STOP, 8'h00, 1'b0);
		open_addr(`PMIC_DEV_ADDR, 1'b1, 1'b0);
		rbytes(8'h40, 18);
		$display("test buffer_full done");
		end_sim();
	end
endmodule : pmic_i2c_register_port_bench
